/* File: design/slbs_regs.svh */
// register offsets, field positions and reset values of the strap block
`ifndef SLBS_REGS_SVH
`define SLBS_REGS_SVH

// register byte offsets
`define SLBS_OFF_STRAP 8'h00
`define SLBS_OFF_STATUS 8'h04
`define SLBS_OFF_CTRL 8'h08

// status register field positions
`define SLBS_ST_MODE_LO 0
`define SLBS_ST_PRINT_BIT 2
`define SLBS_ST_READY_BIT 3

// control register field positions and reset value
`define SLBS_CTRL_DONE_BIT 0
`define SLBS_CTRL_RST 1'h0

// strap latch reset value: third strap pulled high
`define SLBS_STRAP_RST 3'h4

// print policy fuse encodings
`define SLBS_POL_ALWAYS 2'h0
`define SLBS_POL_LOW_ON 2'h1
`define SLBS_POL_HIGH_ON 2'h2
`define SLBS_POL_NEVER 2'h3

`endif

/* File: design/slbs_pkg.sv */
// types shared by the strap latch and boot select block
package slbs_pkg;

	// latched strap bits, first strap in bit 0
	typedef struct packed {
		logic third;
		logic second;
		logic first;
	} slbs_strap_s;

	// system reset sources
	typedef struct packed {
		logic power_on;
		logic rtc_wdt;
		logic brownout;
		logic super_wdt;
		logic xtal_glitch;
	} slbs_rst_cause_s;

	// normal pin function drive after reset
	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
		logic pu_third;
	} slbs_func_s;

	// decoded boot mode
	typedef enum logic [1:0] {
		SLBS_BOOT_FLASH,
		SLBS_BOOT_DOWNLOAD,
		SLBS_BOOT_INVALID,
		SLBS_BOOT_UNDEF
	} slbs_boot_e;

endpackage

/* File: design/slbs_top.sv */
// strap latch, boot mode decode and register port
`timescale 1ns/1ps
`include "slbs_regs.svh"

module slbs_top #(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic chip_en,
	input wire slbs_pkg::slbs_rst_cause_s rst_cause,
	input wire logic [1:0] boot_print_policy_fuse,
	input wire logic [2:0] pad_in,
	output logic [2:0] pad_out,
	output logic [2:0] pad_oe,
	output logic pull_third_en,
	input wire slbs_pkg::slbs_func_s func,
	output slbs_pkg::slbs_boot_e boot_mode,
	output logic boot_print_en,
	output logic boot_ready,
	output logic sys_rst_active,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata
);
	import slbs_pkg::*;

	// refuse address widths that cannot reach every register
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_check
		$error("slbs_top: ADDR_W must be 4 to 32");
	end

	logic [1:0] rst_sync_q;
	logic rst_n;
	slbs_strap_s strap_q, strap_d;
	slbs_boot_e mode_q, mode_d;
	logic ready_q, ready_d;
	logic print_q, print_d;
	logic done_q, done_d;
	logic [2:0] pad_out_q, pad_out_d, pad_oe_q, pad_oe_d;
	logic pu_q, pu_d;
	logic [31:0] rdata_q, rdata_d;
	logic policy_print;

	// reset release through two flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// any reset source or chip enable low holds the system in reset
	assign sys_rst_active = !chip_en || (|rst_cause);

	// print policy from fuse field and second strap
	always_comb begin
		unique case (boot_print_policy_fuse)
			`SLBS_POL_ALWAYS: policy_print = 1'b1;
			`SLBS_POL_LOW_ON: policy_print = !strap_d.second;
			`SLBS_POL_HIGH_ON: policy_print = strap_d.second;
			`SLBS_POL_NEVER: policy_print = 1'b0;
		endcase
	end

	// strap capture, decode and pin release next state
	always_comb begin
		strap_d = strap_q;
		ready_d = !sys_rst_active;
		if (sys_rst_active) begin
			strap_d = pad_in;
		end
		// second strap ignored for flash boot
		if (!strap_d.first) begin
			mode_d = SLBS_BOOT_UNDEF;
		end else if (strap_d.third) begin
			mode_d = SLBS_BOOT_FLASH;
		end else if (strap_d.second) begin
			mode_d = SLBS_BOOT_DOWNLOAD;
		end else begin
			mode_d = SLBS_BOOT_INVALID;
		end
		print_d = policy_print && !done_q;
		// pins tristated with pull-up while in reset
		pad_out_d = sys_rst_active ? 3'h0 : func.out;
		pad_oe_d = sys_rst_active ? 3'h0 : func.oe;
		pu_d = sys_rst_active ? 1'b1 : func.pu_third;
	end

	// register port decode
	always_comb begin
		done_d = done_q;
		rdata_d = 32'h0000_0000;
		if (sys_rst_active) begin
			done_d = `SLBS_CTRL_RST;
		end else if (wr_en && addr == ADDR_W'(`SLBS_OFF_CTRL)) begin
			done_d = wdata[`SLBS_CTRL_DONE_BIT];
		end
		if (rd_en) begin
			unique case (addr)
				ADDR_W'(`SLBS_OFF_STRAP): rdata_d[2:0] = strap_q;
				ADDR_W'(`SLBS_OFF_STATUS): begin
					rdata_d[`SLBS_ST_MODE_LO +: 2] = mode_q;
					rdata_d[`SLBS_ST_PRINT_BIT] = print_q;
					rdata_d[`SLBS_ST_READY_BIT] = ready_q;
				end
				ADDR_W'(`SLBS_OFF_CTRL): rdata_d[`SLBS_CTRL_DONE_BIT] = done_q;
				default: rdata_d = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// state registers, frozen while clock enable is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strap_q <= `SLBS_STRAP_RST;
			mode_q <= SLBS_BOOT_FLASH;
			ready_q <= 1'b0;
			print_q <= 1'b0;
			done_q <= `SLBS_CTRL_RST;
			pad_out_q <= 3'h0;
			pad_oe_q <= 3'h0;
			pu_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			strap_q <= strap_d;
			mode_q <= mode_d;
			ready_q <= ready_d;
			print_q <= print_d;
			done_q <= done_d;
			pad_out_q <= pad_out_d;
			pad_oe_q <= pad_oe_d;
			pu_q <= pu_d;
			rdata_q <= rdata_d;
		end
	end

	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign pull_third_en = pu_q;
	assign boot_mode = mode_q;
	assign boot_print_en = print_q;
	assign boot_ready = ready_q;
	assign rdata = rdata_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// helper: expected print from policy and strap
	function automatic logic exp_print(logic [1:0] pol, logic s2);
		exp_print = (pol == `SLBS_POL_ALWAYS) ||
			(pol == `SLBS_POL_LOW_ON && !s2) ||
			(pol == `SLBS_POL_HIGH_ON && s2);
	endfunction

	a_strap_hold: assert property (
		(clk_en && !sys_rst_active) |=> $stable(strap_q))
		else $error("straps changed outside reset");
	a_strap_sample: assert property (
		(clk_en && sys_rst_active) |=> strap_q == $past(pad_in))
		else $error("straps not sampled in reset");
	a_strap_read: assert property (
		(clk_en && rd_en && addr == ADDR_W'(`SLBS_OFF_STRAP))
		|=> rdata == {29'h0, $past(strap_q)})
		else $error("strap readback wrong");
	a_pull_default: assert property (
		(clk_en && sys_rst_active) |=> pull_third_en)
		else $error("third pull-up off in reset");
	a_pins_tristate: assert property (
		(clk_en && sys_rst_active) |=> pad_oe == 3'h0 && pad_out == 3'h0)
		else $error("pins driven during reset");
	a_pins_released: assert property (
		(clk_en && !sys_rst_active) |=>
		pad_oe == $past(func.oe) && pad_out == $past(func.out))
		else $error("pin drive wrong after reset");
	a_flash_mode: assert property (
		(strap_q.first && strap_q.third && ready_q) |->
		boot_mode == SLBS_BOOT_FLASH)
		else $error("flash boot not selected");
	a_download_mode: assert property (
		(strap_q.first && strap_q.second && !strap_q.third && ready_q) |->
		boot_mode == SLBS_BOOT_DOWNLOAD)
		else $error("download boot not selected");
	a_print_policy: assert property (
		(clk_en && !done_q && !sys_rst_active) |=>
		boot_print_en == exp_print($past(boot_print_policy_fuse),
			$past(strap_q.second)))
		else $error("print enable disagrees with policy");
	a_print_never: assert property (
		(clk_en && boot_print_policy_fuse == `SLBS_POL_NEVER) |=>
		!boot_print_en)
		else $error("print on with policy never");
	a_ready_release: assert property (
		(clk_en && sys_rst_active) ##1 (clk_en && !sys_rst_active) |=>
		boot_ready && $stable(boot_mode))
		else $error("boot not ready after reset release");
	a_chip_en_reset: assert property (
		(clk_en && !chip_en) |=> !boot_ready)
		else $error("chip enable low did not reset");

	c_flash_boot: cover property ($rose(boot_ready) &&
		boot_mode == SLBS_BOOT_FLASH);
	c_download_boot: cover property ($rose(boot_ready) &&
		boot_mode == SLBS_BOOT_DOWNLOAD);
	c_print_done: cover property ($fell(boot_print_en) && done_q);
	c_strap_read: cover property (rd_en &&
		addr == ADDR_W'(`SLBS_OFF_STRAP) && !sys_rst_active);

endmodule

/* File: verification/slbs_strap_drv.sv */
// strap pin level model: external drive, weak pull-up, floating pins
`timescale 1ns/1ps
module slbs_strap_drv (
	input wire logic clock,
	input wire logic [2:0] ext_val,
	input wire logic [2:0] ext_en,
	input wire logic [2:0] pad_out,
	input wire logic [2:0] pad_oe,
	input wire logic pull_third_en,
	output logic [2:0] pad_in
);
	logic flt = 1'b0;
	// a floating pin wanders every cycle
	always @(posedge clock) flt <= ~flt;
	// chip drive wins, then the external party, then the pull-up
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (pad_oe[i]) pad_in[i] = pad_out[i];
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (i == 2 && pull_third_en) pad_in[i] = 1'b1;
			else pad_in[i] = flt;
		end
	end
endmodule

/* File: verification/strap_latch_boot_select_tb.sv */
// self-checking bench for the strap latch and boot select block
`timescale 1ns/1ps
`include "slbs_regs.svh"
module strap_latch_boot_select_tb;
	import slbs_pkg::*;
	logic clock, arst_n, clk_en, chip_en, wr_en, rd_en;
	slbs_rst_cause_s rst_cause;
	slbs_func_s func;
	slbs_boot_e boot_mode;
	logic [1:0] fuse;
	logic [2:0] pad_in, pad_out, pad_oe, ext_val, ext_en, s, e, v;
	logic pull_third_en, boot_print_en, boot_ready, sys_rst_active;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	int n_fail = 0;
	int total_checks = 0;

	slbs_top #(.ADDR_W(8)) dut (.clock(clock), .arst_n(arst_n),
		.clk_en(clk_en), .chip_en(chip_en), .rst_cause(rst_cause),
		.boot_print_policy_fuse(fuse), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pull_third_en(pull_third_en), .func(func),
		.boot_mode(boot_mode), .boot_print_en(boot_print_en),
		.boot_ready(boot_ready), .sys_rst_active(sys_rst_active),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata));
	slbs_strap_drv drv (.clock(clock), .ext_val(ext_val), .ext_en(ext_en),
		.pad_out(pad_out), .pad_oe(pad_oe),
		.pull_third_en(pull_third_en), .pad_in(pad_in));

	// free-running clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// expected mode from latched straps
	function automatic logic [1:0] exp_mode(logic [2:0] b);
		if (!b[0]) return SLBS_BOOT_UNDEF;
		if (b[2]) return SLBS_BOOT_FLASH;
		if (b[1]) return SLBS_BOOT_DOWNLOAD;
		return SLBS_BOOT_INVALID;
	endfunction

	// expected print enable from policy and second strap
	function automatic logic exp_print(logic [1:0] f, logic sec);
		case (f)
			2'h0: return 1'b1;
			2'h1: return !sec;
			2'h2: return sec;
			default: return 1'b0;
		endcase
	endfunction

	task chk(logic [31:0] got, logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task rd(logic [7:0] a, logic [31:0] exp);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	task wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask

	// one system reset from a given source, then readback
	task boot(int src, logic [1:0] f);
		v = {e[2] ? s[2] : 1'b1, s[1:0]};
		@(posedge clock);
		if (src > 4) chip_en <= 1'b0;
		else rst_cause <= 5'h01 << src;
		ext_val <= s;
		ext_en <= e;
		fuse <= f;
		func <= 7'($urandom);
		repeat (4) @(posedge clock);
		#1 chk({pad_oe, pull_third_en, boot_ready}, 5'h02);
		@(posedge clock);
		chip_en <= 1'b1;
		rst_cause <= '0;
		ext_val <= ~s;
		ext_en <= 3'h7;
		repeat (2) @(posedge clock);
		#1 chk(boot_mode, exp_mode(v));
		chk(boot_print_en, exp_print(f, v[1]));
		chk({pad_oe, pull_third_en}, {func.oe, func.pu_third});
		rd(`SLBS_OFF_STRAP, {29'h0, v});
		rd(`SLBS_OFF_STATUS, {1'b1, exp_print(f, v[1]), exp_mode(v)});
	endtask

	task results;
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		chip_en = 1'b1;
		rst_cause = '0;
		fuse = '0;
		func = '0;
		addr = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		ext_val = '0;
		ext_en = '0;
		void'($urandom(32'h21d8_5b2f));
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rd(`SLBS_OFF_STRAP, 32'h0000_0004);
		for (int i = 0; i < 24; i++) begin
			s = 3'($urandom);
			s[0] = (i != 7);
			if (s[2:1] == 2'h0) s[2] = 1'b1;
			e = {1'($urandom), 2'h3};
			boot(i % 6, 2'(i % 4));
		end
		// policy that prints, then print-done silences it
		@(posedge clock);
		fuse <= `SLBS_POL_ALWAYS;
		repeat (2) @(posedge clock);
		#1 chk(boot_print_en, 1'b1);
		wr(`SLBS_OFF_CTRL, 32'h0000_0001);
		wr(`SLBS_OFF_STRAP, 32'h0000_0000);
		rd(`SLBS_OFF_STRAP, {29'h0, v});
		rd(`SLBS_OFF_CTRL, 32'h0000_0001);
		chk(boot_print_en, 1'b0);
		rd(8'h0C, 32'h0000_0000);
		boot(5, 2'h0);
		rd(`SLBS_OFF_CTRL, 32'h0000_0000);
		// clock enable low freezes state through a reset request
		@(posedge clock);
		clk_en <= 1'b0;
		chip_en <= 1'b0;
		ext_val <= ~v;
		repeat (3) @(posedge clock);
		#1 chk(boot_ready, 1'b1);
		@(posedge clock);
		chip_en <= 1'b1;
		clk_en <= 1'b1;
		rd(`SLBS_OFF_STRAP, {29'h0, v});
		results;
	end

	// watchdog
	initial begin
		repeat (5000) @(posedge clock);
		n_fail++;
		results;
	end
endmodule
